// ===== mtpc_pkg.sv
`default_nettype none
package mtpc_pkg;
    // ==========================================================
    // Clock and drive frequency
    localparam int CLK_HZ        = 25_000_000;
    localparam int FREQ_MIN_HZ   = 105_000;
    localparam int FREQ_MAX_HZ   = 113_000;
    localparam int HALF_W        = 8;
    // Shortest half period rounds up, longest rounds down: both stay in band
    localparam int HALF_MIN      = (CLK_HZ + 2 * FREQ_MAX_HZ - 1) / (2 * FREQ_MAX_HZ);
    localparam int HALF_MAX      = CLK_HZ / (2 * FREQ_MIN_HZ);
    localparam int HALF_INIT     = (HALF_MIN + HALF_MAX) / 2;
    localparam logic [HALF_W-1:0] HALF_MIN_C  = HALF_W'(HALF_MIN);
    localparam logic [HALF_W-1:0] HALF_MAX_C  = HALF_W'(HALF_MAX);
    localparam logic [HALF_W-1:0] HALF_INIT_C = HALF_W'(HALF_INIT);

    // ==========================================================
    // Inverter input voltage, millivolt units
    localparam int VW                   = 15;
    localparam logic [VW-1:0] VIN_MIN_MV  = 15'h0000;
    localparam logic [VW-1:0] VIN_MAX_MV  = 15'h4E20;
    localparam logic [VW-1:0] PING_MV     = 15'h2EE0;
    localparam logic [VW-1:0] CAP_STEP_MV = 15'h0023;

    // ==========================================================
    // Cell current, milliamp RMS units
    localparam int IW                        = 13;
    localparam logic [IW-1:0] ILIM_MULTI_MA  = 13'h0FA0;
    localparam logic [IW-1:0] ILIM_SINGLE_MA = 13'h07D0;

    // ==========================================================
    // Loop constants
    localparam int signed KP_PER_MA   = 1;
    localparam int signed SCALE_MV    = -1;
    localparam logic signed [15:0] PID_LIM = 16'sh07D0;

    // ==========================================================
    // Control update and session timeouts
    localparam int CTRL_PERIOD_US     = 1000;
    localparam int CTRL_CYCLES        = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
    localparam int PING_TIMEOUT_MS    = 25;
    localparam int XFER_TIMEOUT_MS    = 1800;
    localparam int WD_W               = 11;
    localparam logic [WD_W-1:0] PING_TO_TICKS =
        WD_W'(PING_TIMEOUT_MS * 1000 / CTRL_PERIOD_US);
    localparam logic [WD_W-1:0] XFER_TO_TICKS =
        WD_W'(XFER_TIMEOUT_MS * 1000 / CTRL_PERIOD_US);

    // ==========================================================
    // Message headers and group size
    localparam logic [7:0] HDR_CTRL_ERR  = 8'h03;
    localparam logic [7:0] HDR_END_POWER = 8'h02;
    localparam int MAX_GROUP = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_PING, ST_XFER} mtpc_state_t;
endpackage
`default_nettype wire

// ===== mtpc_group_check.sv
`timescale 1ns/10ps
`default_nettype none
module mtpc_group_check #(
    parameter int NC = 8
) (
    input  wire logic [NC-1:0]    coils,
    input  wire logic [NC*NC-1:0] overlap,
    input  wire logic [NC-1:0]    busy,
    output logic                  ok,
    output logic                  multi
);
    localparam int CW = $clog2(NC + 1);
    logic [NC-1:0] bad;
    logic [CW-1:0] cnt;

    // ==========================================================
    // Every chosen coil must overlap every other chosen coil
    for (genvar i = 0; i < NC; i++) begin : g_pair
        localparam logic [NC-1:0] SELF = NC'(1) << i;
        assign bad[i] = coils[i] & (|(coils & ~overlap[i*NC +: NC] & ~SELF));
    end

    always_comb begin
        cnt = '0;
        for (int k = 0; k < NC; k++) begin
            cnt = cnt + CW'(coils[k]);
        end
    end

    // ==========================================================
    // One to three coils, no pair apart, none held by another transmitter
    always_comb begin
        ok = (cnt >= CW'(1)) && (cnt <= CW'(mtpc_pkg::MAX_GROUP))
            && !(|bad)
            && !(|(coils & busy));
        multi = (cnt >= CW'(2));
    end
endmodule
`default_nettype wire

// ===== mtpc_half_bridge_div.sv
`timescale 1ns/10ps
`default_nettype none
module mtpc_half_bridge_div #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic [W-1:0] half_period,
    output logic              drive
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] period;
        logic         level;
    } mtpc_div_st_t;

    mtpc_div_st_t s;
    mtpc_div_st_t next_s;

    // ==========================================================
    // Period reloads only at the end of a full cycle, so duty stays 50%
    always_comb begin
        next_s = s;
        if (!en) begin
            next_s.cnt    = '0;
            next_s.level  = 1'b0;
            next_s.period = half_period;
        end else if (s.cnt >= s.period - W'(1)) begin
            next_s.cnt   = '0;
            next_s.level = ~s.level;
            if (s.level) begin
                next_s.period = half_period;
            end
        end else begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign drive = s.level;
endmodule
`default_nettype wire

// ===== mtpc_ctrl.sv
// Overview of operation
// - Decode receiver messages; drive mux, frequency, voltage.
// - Coil group follows the receiver position.
// - Group holds one, two or three coils.
// - Every selected coil overlaps all others.
// - Parallel switch open for one coil only.
// - Drive frequency kept within 105-113 kHz.
// - Voltage commanded over 0 to 20 V.
// - Setpoint steps no coarser than 35 mV.
// - Digital ping starts at 12 V.
// - PID loop controls inverter input voltage.
// - Cell current measured to 5 mA.
// - Cap current 4 A multi, 2 A single.
// - Lower the voltage ceiling to cap current.
// - Gain 1/mA, limit 2000, scale -1 mV.
// - One receiver served per instance.
// - Own inverter and current sense per instance.
// - No coil shared between two inverters.
`timescale 1ns/10ps
`default_nettype none
module mtpc_ctrl #(
    parameter int               NC          = 8,
    parameter logic [NC*NC-1:0] OVERLAP     = '1,
    parameter int               CTRL_CYCLES = mtpc_pkg::CTRL_CYCLES
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         ping_start,
    input  wire logic                         power_stop,
    input  wire logic                         pos_valid,
    input  wire logic [NC-1:0]                pos_coils,
    input  wire logic [NC-1:0]                other_tx_coils,
    input  wire logic                         msg_valid,
    input  wire logic [7:0]                   msg_header,
    input  wire logic [7:0]                   msg_payload,
    input  wire logic                         cur_valid,
    input  wire logic [mtpc_pkg::IW-1:0]      cur_ma,
    input  wire logic                         freq_valid,
    input  wire logic [mtpc_pkg::HALF_W-1:0]  freq_half_period,
    output logic [NC-1:0]                     coil_sel,
    output logic                              parallel_sw,
    output logic                              inverter_drive,
    output logic [mtpc_pkg::HALF_W-1:0]       drive_frequency,
    output logic [mtpc_pkg::VW-1:0]           volt_setpoint_mv,
    output logic                              power_active,
    output logic                              group_reject,
    output logic                              current_limited,
    output logic                              session_abort
);
    localparam int TW = $clog2(CTRL_CYCLES + 1);
    localparam int VW = mtpc_pkg::VW;
    localparam int IW = mtpc_pkg::IW;
    localparam int WW = mtpc_pkg::WD_W;

    typedef struct packed {
        mtpc_pkg::mtpc_state_t         state;
        logic [TW-1:0]                 tick_cnt;
        logic                          tick;
        logic [WW-1:0]                 wd_cnt;
        logic [NC-1:0]                 coil_sel;
        logic                          parallel_sw;
        logic [mtpc_pkg::HALF_W-1:0]   half_period;
        logic [VW-1:0]                 setpoint;
        logic [VW-1:0]                 ceiling;
        logic [IW-1:0]                 i_meas;
        logic [IW:0]                   target;
        logic                          target_ok;
        logic                          power_active;
        logic                          group_reject;
        logic                          current_limited;
        logic                          session_abort;
    } mtpc_ctrl_st_t;

    mtpc_ctrl_st_t s;
    mtpc_ctrl_st_t next_s;

    logic chk_ok;
    logic chk_multi;
    logic drive_q;

    // ==========================================================
    // Group check and inverter divider
    mtpc_group_check #(
        .NC (NC)
    ) u_check (
        .coils   (pos_coils),
        .overlap (OVERLAP),
        .busy    (other_tx_coils),
        .ok      (chk_ok),
        .multi   (chk_multi)
    );

    mtpc_half_bridge_div #(
        .W (mtpc_pkg::HALF_W)
    ) u_div (
        .clk         (clk),
        .rst_n       (rst_n),
        .en          (s.power_active),
        .half_period (s.half_period),
        .drive       (drive_q)
    );

    // ==========================================================
    // Next state
    logic signed [VW+1:0] cand;
    logic signed [15:0]   err;
    logic signed [15:0]   pid_raw;
    logic signed [15:0]   pid;
    logic signed [21:0]   prod;
    logic signed [15:0]   tgt;
    logic [IW-1:0]        lim;
    logic                 over;
    logic                 is_ctrl;
    logic                 is_end;
    logic                 conflict;
    logic                 wd_expired;

    always_comb begin
        cand       = '0;
        err        = '0;
        pid_raw    = '0;
        pid        = '0;
        prod       = '0;
        tgt        = '0;
        lim        = '0;
        over       = 1'b0;
        is_ctrl    = 1'b0;
        is_end     = 1'b0;
        conflict   = 1'b0;
        wd_expired = 1'b0;
        next_s     = s;
        next_s.group_reject  = 1'b0;
        next_s.session_abort = 1'b0;
        next_s.tick          = 1'b0;

        // Control update tick
        if (s.tick_cnt == TW'(CTRL_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + TW'(1);
        end

        // Only this instance's own sense channel feeds its loop
        if (cur_valid) begin
            next_s.i_meas = cur_ma;
        end

        // Frequency request held inside the operating band
        if (freq_valid) begin
            if (freq_half_period < mtpc_pkg::HALF_MIN_C) begin
                next_s.half_period = mtpc_pkg::HALF_MIN_C;
            end else if (freq_half_period > mtpc_pkg::HALF_MAX_C) begin
                next_s.half_period = mtpc_pkg::HALF_MAX_C;
            end else begin
                next_s.half_period = freq_half_period;
            end
        end

        // ======================================================
        // Current cap, independent of the loop
        lim  = s.parallel_sw ? mtpc_pkg::ILIM_MULTI_MA : mtpc_pkg::ILIM_SINGLE_MA;
        over = s.power_active && (s.i_meas > lim);
        if (over) begin
            // Ceiling drops below the present setpoint each cycle over limit
            if (s.setpoint > mtpc_pkg::CAP_STEP_MV) begin
                next_s.ceiling = s.setpoint - mtpc_pkg::CAP_STEP_MV;
            end else begin
                next_s.ceiling = mtpc_pkg::VIN_MIN_MV;
            end
            next_s.current_limited = 1'b1;
        end else if (s.tick) begin
            // Slow release avoids bouncing off the cap
            if (s.ceiling > mtpc_pkg::VIN_MAX_MV - mtpc_pkg::CAP_STEP_MV) begin
                next_s.ceiling = mtpc_pkg::VIN_MAX_MV;
            end else begin
                next_s.ceiling = s.ceiling + mtpc_pkg::CAP_STEP_MV;
            end
            next_s.current_limited = 1'b0;
        end

        // ======================================================
        // Message decode and session watchdog
        is_ctrl  = msg_valid && (msg_header == mtpc_pkg::HDR_CTRL_ERR);
        is_end   = msg_valid && (msg_header == mtpc_pkg::HDR_END_POWER);
        conflict = |(s.coil_sel & other_tx_coils);
        if (s.tick && (s.wd_cnt != '1)) begin
            next_s.wd_cnt = s.wd_cnt + WW'(1);
        end
        wd_expired = (s.state == mtpc_pkg::ST_PING) ? (s.wd_cnt >= mtpc_pkg::PING_TO_TICKS)
                                                    : (s.wd_cnt >= mtpc_pkg::XFER_TO_TICKS);

        cand = $signed({2'b00, s.setpoint});

        case (s.state)
            mtpc_pkg::ST_IDLE: begin
                if (pos_valid) begin
                    if (chk_ok) begin
                        next_s.coil_sel    = pos_coils;
                        next_s.parallel_sw = chk_multi;
                    end else begin
                        next_s.group_reject = 1'b1;
                    end
                end
                if (ping_start && (|s.coil_sel) && !conflict) begin
                    next_s.state        = mtpc_pkg::ST_PING;
                    next_s.power_active = 1'b1;
                    next_s.ceiling      = mtpc_pkg::VIN_MAX_MV;
                    next_s.target_ok    = 1'b0;
                    next_s.wd_cnt       = '0;
                    cand = $signed({2'b00, mtpc_pkg::PING_MV});
                end
            end
            mtpc_pkg::ST_PING, mtpc_pkg::ST_XFER: begin
                // Group is frozen while a receiver is served
                if (pos_valid) begin
                    next_s.group_reject = 1'b1;
                end
                if (power_stop || is_end || conflict || wd_expired) begin
                    next_s.state         = mtpc_pkg::ST_IDLE;
                    next_s.power_active  = 1'b0;
                    next_s.target_ok     = 1'b0;
                    next_s.session_abort = conflict || wd_expired;
                    cand = '0;
                end else begin
                    if (is_ctrl) begin
                        // Target current scaled by one plus the signed error over 128
                        prod = $signed({1'b0, s.i_meas}) * $signed(msg_payload);
                        tgt  = 16'($signed({3'b000, s.i_meas}) + (prod >>> 7));
                        next_s.target    = (tgt < 0) ? '0 : tgt[IW:0];
                        next_s.target_ok = 1'b1;
                        next_s.state     = mtpc_pkg::ST_XFER;
                        next_s.wd_cnt    = '0;
                    end
                    if ((s.state == mtpc_pkg::ST_XFER) && s.tick && s.target_ok) begin
                        // Proportional path only: integral and derivative gains are zero
                        err     = $signed({3'b000, s.i_meas}) - $signed({2'b00, s.target});
                        pid_raw = 16'(mtpc_pkg::KP_PER_MA * err);
                        if (pid_raw > mtpc_pkg::PID_LIM) begin
                            pid = mtpc_pkg::PID_LIM;
                        end else if (pid_raw < -mtpc_pkg::PID_LIM) begin
                            pid = -mtpc_pkg::PID_LIM;
                        end else begin
                            pid = pid_raw;
                        end
                        // One count of loop output lowers the setpoint by one millivolt
                        cand = (VW+2)'($signed({2'b00, s.setpoint})
                               + mtpc_pkg::SCALE_MV * pid);
                    end
                end
            end
            default: begin
                next_s.state        = mtpc_pkg::ST_IDLE;
                next_s.power_active = 1'b0;
                cand = '0;
            end
        endcase

        // ======================================================
        // Setpoint saturation
        if (cand < 0) begin
            next_s.setpoint = mtpc_pkg::VIN_MIN_MV;
        end else if (cand > $signed({2'b00, next_s.ceiling})) begin
            next_s.setpoint = next_s.ceiling;
        end else begin
            next_s.setpoint = cand[VW-1:0];
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s             <= '0;
            s.state       <= mtpc_pkg::ST_IDLE;
            s.ceiling     <= mtpc_pkg::VIN_MAX_MV;
            s.half_period <= mtpc_pkg::HALF_INIT_C;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign coil_sel         = s.coil_sel;
    assign parallel_sw      = s.parallel_sw;
    assign inverter_drive   = drive_q;
    assign drive_frequency  = s.half_period;
    assign volt_setpoint_mv = s.setpoint;
    assign power_active     = s.power_active;
    assign group_reject     = s.group_reject;
    assign current_limited  = s.current_limited;
    assign session_abort    = s.session_abort;
endmodule
`default_nettype wire

// ===== mtpc_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mtpc_ctrl_monitor #(
    parameter int NC = 8
) (
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        pos_valid,
    input wire logic [NC-1:0]               other_tx_coils,
    input wire logic                        cur_valid,
    input wire logic [mtpc_pkg::IW-1:0]     cur_ma,
    input wire logic [NC-1:0]               coil_sel,
    input wire logic                        parallel_sw,
    input wire logic                        inverter_drive,
    input wire logic [mtpc_pkg::HALF_W-1:0] drive_frequency,
    input wire logic [mtpc_pkg::VW-1:0]     volt_setpoint_mv,
    input wire logic                        power_active,
    input wire logic                        group_reject,
    input wire logic                        current_limited,
    input wire logic                        session_abort
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Cap depends on the group size now applied
    logic [mtpc_pkg::IW-1:0] cur_cap;
    assign cur_cap = parallel_sw ? mtpc_pkg::ILIM_MULTI_MA : mtpc_pkg::ILIM_SINGLE_MA;
    // ==========================================================
    sw_follows_group_a: assert property (
        parallel_sw == ($countones(coil_sel) > 1))
        else $error("parallel switch disagrees with group size");
    group_size_a: assert property (
        $countones(coil_sel) <= 3)
        else $error("more than three coils selected");
    freq_band_a: assert property (
        drive_frequency >= mtpc_pkg::HALF_MIN_C && drive_frequency <= mtpc_pkg::HALF_MAX_C)
        else $error("drive half period out of band");
    volt_span_a: assert property (
        volt_setpoint_mv <= mtpc_pkg::VIN_MAX_MV)
        else $error("setpoint above span");
    ping_volt_a: assert property (
        $rose(power_active) |-> volt_setpoint_mv == mtpc_pkg::PING_MV)
        else $error("ping did not start at initial voltage");
    busy_reject_a: assert property (
        pos_valid && power_active |=> group_reject && $stable(coil_sel))
        else $error("group change accepted during session");
    shared_coil_a: assert property (
        power_active && |(coil_sel & other_tx_coils) |=> !power_active && session_abort)
        else $error("shared coil not released");
    cap_flag_a: assert property (
        power_active && cur_valid && cur_ma > cur_cap |-> ##[1:3] current_limited)
        else $error("over current not flagged");
    cap_lower_a: assert property (
        power_active && $past(power_active) && current_limited |->
        volt_setpoint_mv <= $past(volt_setpoint_mv))
        else $error("setpoint rose while current capped");
    loop_step_a: assert property (
        power_active && $past(power_active) |->
        (volt_setpoint_mv > $past(volt_setpoint_mv) ?
         volt_setpoint_mv - $past(volt_setpoint_mv) :
         $past(volt_setpoint_mv) - volt_setpoint_mv) <= 15'h07D0)
        else $error("setpoint step above loop limit");
    drive_idle_a: assert property (
        (!power_active)[*3] |-> !inverter_drive)
        else $error("inverter driven while idle");
    ping_c: cover property ($rose(power_active));
    reject_c: cover property (group_reject);
    cap_c: cover property (current_limited);
    abort_c: cover property (session_abort);
endmodule
`default_nettype wire

// ===== mtpc_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
module mtpc_rx_model (
    input  wire logic       clk,
    output logic            msg_valid,
    output logic [7:0]      msg_header,
    output logic [7:0]      msg_payload
);
    initial begin
        msg_valid = 1'b0;
        msg_header = 8'hFF;
        msg_payload = 8'h00;
    end
    // ==========================================================
    // One decoded message, one clock wide
    task automatic send(input logic [7:0] hdr, input logic [7:0] pay);
        @(negedge clk);
        msg_header = hdr;
        msg_payload = pay;
        msg_valid = 1'b1;
        @(negedge clk);
        msg_valid = 1'b0;
        // Fields go stale after the strobe, never left looking valid
        msg_header = ~hdr;
        msg_payload = ~pay;
    endtask
endmodule
`default_nettype wire

// ===== test_multi_coil_tx_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_multi_coil_tx_power_control;
    typedef struct packed {logic [7:0] pos; logic [7:0] oth; logic rej;} mtpc_row_t;
    // ==========================================================
    // Coils overlap their two neighbours on each side
    function automatic logic [63:0] band_overlap();
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 8; j++) begin
                if (i - j <= 2 && j - i <= 2) begin
                    m[i*8+j] = 1'b1;
                end
            end
        end
        return m;
    endfunction
    localparam logic [63:0] OVL = band_overlap();
    logic        clk, rst_n, ping_start, power_stop, pos_valid, cur_valid, freq_valid;
    logic [7:0]  pos_coils, other_tx_coils, freq_half_period, coil_sel, drive_frequency;
    logic [7:0]  msg_header, msg_payload;
    logic [12:0] cur_ma;
    logic [14:0] volt_setpoint_mv, prev_mv;
    logic        msg_valid, parallel_sw, inverter_drive, power_active;
    logic        group_reject, current_limited, session_abort;
    logic [7:0]  prev = 8'h00;
    int          err_count, samples_checked, n;
    mtpc_row_t   rows [9] = '{'{8'h01, 8'h00, 1'b0}, '{8'h03, 8'h00, 1'b0},
        '{8'h07, 8'h00, 1'b0}, '{8'h0F, 8'h00, 1'b1}, '{8'h00, 8'h00, 1'b1},
        '{8'h11, 8'h00, 1'b1}, '{8'h05, 8'h00, 1'b0}, '{8'h30, 8'h10, 1'b1},
        '{8'hC0, 8'h01, 1'b0}};
    logic [7:0]  freq_req [3] = '{8'h50, 8'hFF, 8'h71};
    logic [7:0]  freq_exp [3] = '{mtpc_pkg::HALF_MIN_C, mtpc_pkg::HALF_MAX_C, 8'h71};
    mtpc_ctrl #(.NC(8), .OVERLAP(OVL), .CTRL_CYCLES(40)) i_dut (
        .clk(clk), .rst_n(rst_n), .ping_start(ping_start), .power_stop(power_stop),
        .pos_valid(pos_valid), .pos_coils(pos_coils), .other_tx_coils(other_tx_coils),
        .msg_valid(msg_valid), .msg_header(msg_header), .msg_payload(msg_payload),
        .cur_valid(cur_valid), .cur_ma(cur_ma), .freq_valid(freq_valid),
        .freq_half_period(freq_half_period), .coil_sel(coil_sel), .parallel_sw(parallel_sw),
        .inverter_drive(inverter_drive), .drive_frequency(drive_frequency),
        .volt_setpoint_mv(volt_setpoint_mv), .power_active(power_active),
        .group_reject(group_reject), .current_limited(current_limited),
        .session_abort(session_abort));
    mtpc_rx_model i_rx (.clk(clk), .msg_valid(msg_valid), .msg_header(msg_header),
        .msg_payload(msg_payload));
    // ==========================================================
    // Shared checks and drivers
    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (!ok) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic select(input logic [7:0] pos);
        pos_coils = pos;
        pos_valid = 1'b1;
        @(negedge clk);
        pos_valid = 1'b0;
    endtask
    task automatic ping();
        ping_start = 1'b1;
        @(negedge clk);
        ping_start = 1'b0;
    endtask
    task automatic sense(input logic [12:0] ma);
        cur_ma = ma;
        cur_valid = 1'b1;
        @(negedge clk);
        cur_valid = 1'b0;
    endtask
    task automatic wait_change(input logic [14:0] want);
        logic [14:0] old;
        old = volt_setpoint_mv;
        n = 0;
        while (volt_setpoint_mv === old && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(volt_setpoint_mv === want, "loop setpoint");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run needs about 300 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        {rst_n, ping_start, power_stop, pos_valid, cur_valid, freq_valid} = '0;
        {pos_coils, other_tx_coils, freq_half_period, cur_ma} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        foreach (rows[k]) begin
            other_tx_coils = rows[k].oth;
            select(rows[k].pos);
            if (!rows[k].rej) prev = rows[k].pos;
            chk(group_reject === rows[k].rej, "reject flag");
            chk(coil_sel === prev, "coil group");
            chk(parallel_sw === ($countones(prev) > 1), "parallel switch");
            @(negedge clk);
        end
        other_tx_coils = 8'h00;
        freq_valid = 1'b1;
        for (int k = 0; k < 3; k++) begin
            freq_half_period = freq_req[k];
            @(negedge clk);
            chk(drive_frequency === freq_exp[k], "drive frequency");
        end
        freq_valid = 1'b0;
        // Session on a single coil: ping, loop, cap, end
        select(8'h01);
        ping();
        chk(power_active === 1'b1 && volt_setpoint_mv === mtpc_pkg::PING_MV, "ping");
        n = 0;
        while (inverter_drive !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk(inverter_drive === 1'b1, "inverter idle");
        select(8'h03);
        chk(group_reject === 1'b1 && coil_sel === 8'h01, "busy select");
        sense(13'h03E8);
        i_rx.send(8'h03, 8'h00);
        sense(13'h05DC);
        wait_change(15'h2CEC);
        sense(13'h076C);
        i_rx.send(8'h03, 8'h7F);
        wait_change(15'h3449);
        sense(13'h0064);
        wait_change(15'h3C19);
        prev_mv = volt_setpoint_mv;
        sense(13'h0834);
        repeat (3) @(negedge clk);
        chk(current_limited === 1'b1, "cap flag");
        chk((volt_setpoint_mv < prev_mv) === 1'b1, "cap setpoint");
        sense(13'h0000);
        i_rx.send(8'h02, 8'h00);
        @(negedge clk);
        chk(power_active === 1'b0 && volt_setpoint_mv === 15'h0000, "end power");
        // Coil taken by another transmitter mid-session
        ping();
        other_tx_coils = 8'h01;
        @(negedge clk);
        chk(session_abort === 1'b1 && power_active === 1'b0, "shared coil");
        other_tx_coils = 8'h00;
        ping();
        power_stop = 1'b1;
        @(negedge clk);
        power_stop = 1'b0;
        chk(power_active === 1'b0 && session_abort === 1'b0, "power stop");
        ping();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(power_active === 1'b0 && coil_sel === 8'h00, "reset state");
        chk(volt_setpoint_mv === 15'h0000, "reset setpoint");
        chk(drive_frequency === mtpc_pkg::HALF_INIT_C, "reset frequency");
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        give_verdict();
    end
endmodule
bind mtpc_ctrl mtpc_ctrl_monitor #(.NC(NC)) i_mon (
    .clk(clk), .rst_n(rst_n), .pos_valid(pos_valid), .other_tx_coils(other_tx_coils),
    .cur_valid(cur_valid), .cur_ma(cur_ma), .coil_sel(coil_sel), .parallel_sw(parallel_sw),
    .inverter_drive(inverter_drive), .drive_frequency(drive_frequency),
    .volt_setpoint_mv(volt_setpoint_mv), .power_active(power_active),
    .group_reject(group_reject), .current_limited(current_limited),
    .session_abort(session_abort));
`default_nettype wire
